/* design/trace_readout_pkg.sv */
package trace_readout_pkg;

   // Bus and data widths
   localparam int ADDR_W  = 8;
   localparam int DATA_W  = 16;
   localparam int LINE_W  = 64;
   localparam int SRC_W   = 2;

   // Trace store geometry: 64 lines of four 16-bit portions
   localparam int DEPTH   = 64;
   localparam int LINE_AW = 6;
   localparam int PART_AW = 2;
   localparam int PTR_W   = LINE_AW + PART_AW;

   // Register offsets (byte addresses on the plain port)
   localparam logic [ADDR_W-1:0] CTRL_ADDR   = 8'h20;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h22;
   localparam logic [ADDR_W-1:0] WIN_ADDR    = 8'h24;
   localparam logic [ADDR_W-1:0] WIN_ADDR_HI = 8'h25;
   localparam logic [ADDR_W-1:0] WRPTR_ADDR  = 8'h28;

   // Control register fields
   localparam int CTRL_ARM_BIT = 0;
   localparam int CTRL_SRC_LSB = 1;

   // Status register fields
   localparam int STAT_UNLOCK_BIT  = 0;
   localparam int STAT_ARMED_BIT   = 1;
   localparam int STAT_SECURED_BIT = 2;
   localparam int STAT_WRAP_BIT    = 3;
   localparam int STAT_PTR_LSB     = 8;

   // Reset values and step constants
   localparam logic [SRC_W-1:0]   SRC_RESET  = 2'h0;
   localparam logic [PTR_W-1:0]   PTR_ZERO   = 8'h00;
   localparam logic [PTR_W-1:0]   PTR_ONE    = 8'h01;
   localparam logic [LINE_AW-1:0] LINE_ZERO  = 6'h00;
   localparam logic [LINE_AW-1:0] LINE_ONE   = 6'h01;
   localparam logic [LINE_AW-1:0] LAST_LINE  = 6'h3f;
   localparam logic [PART_AW-1:0] PART_ZERO  = 2'h0;
   localparam logic [DATA_W-1:0]  DATA_ZERO  = 16'h0000;
   localparam logic [LINE_W-1:0]  LINE_CLEAR = 64'h0000_0000_0000_0000;

   // Two-entry buffer occupancy
   localparam logic [1:0] CNT_EMPTY = 2'h0;
   localparam logic [1:0] CNT_ONE   = 2'h1;
   localparam logic [1:0] CNT_FULL  = 2'h2;

endpackage

/* design/trace_line_store.sv */
`timescale 1ns/1ps
module trace_line_store
   import trace_readout_pkg::*;
(
   // Clock and enable
   input  wire logic               sys_clk,
   input  wire logic               clk_en,
   // Write side
   input  wire logic               wr_en,
   input  wire logic [LINE_AW-1:0] wr_addr,
   input  wire logic [LINE_W-1:0]  wr_data,
   // Read side
   input  wire logic [LINE_AW-1:0] rd_addr,
   output      logic [LINE_W-1:0]  rd_data
);

   // No reset on the array: contents survive everything but power-up
   logic [LINE_W-1:0] lines [DEPTH];

   // Asynchronous read; the caller registers the selected portion
   assign rd_data = lines[rd_addr];

   // Write only while the clock enable lets state move
   always_ff @(posedge sys_clk) begin
      if (clk_en && wr_en) begin
         lines[wr_addr] <= wr_data;
      end
   end

endmodule

/* design/two_entry_buffer.sv */
`timescale 1ns/1ps
module two_entry_buffer
   import trace_readout_pkg::*;
#(
   parameter int WIDTH = LINE_W
)
(
   // Clock, reset and enable
   input  wire logic             sys_clk,
   input  wire logic             reset_n,
   input  wire logic             clk_en,
   // Filling side
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Draining side
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);

   logic [WIDTH-1:0] head;
   logic [WIDTH-1:0] tail;
   logic [1:0]       count;
   logic [1:0]       next_count;
   logic [WIDTH-1:0] next_head;
   logic [WIDTH-1:0] next_tail;
   logic             push;
   logic             pop;

   // Handshakes; ready is a flop so the source sees a clean level
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_valid = (count != CNT_EMPTY);
   assign out_data  = head;

   // Occupancy and slot steering
   assign next_count = (push && !pop) ? count + CNT_ONE :
                       (pop && !push) ? count - CNT_ONE : count;
   assign next_head  = (push && (pop || count == CNT_EMPTY)) ?
                       (pop && count == CNT_FULL ? tail : in_data) :
                       (pop ? tail : head);
   assign next_tail  = (push && !pop && count == CNT_ONE) ? in_data : tail;

   // Data slots need no reset; occupancy does
   always_ff @(posedge sys_clk) begin
      if (clk_en) begin
         head <= next_head;
         tail <= next_tail;
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         count    <= CNT_EMPTY;
         in_ready <= 1'b0;
      end else if (clk_en) begin
         count    <= next_count;
         in_ready <= (next_count != CNT_FULL);
      end
   end

endmodule

/* design/trace_buffer_readout.sv */
// Implementation choice: strobed register access.
`timescale 1ns/1ps
// Behaviour
// - Valid data needs unlocked, unsecured, disarmed, source set
// - Aligned word write while disarmed unlocks
// - Window write never alters stored trace lines
// - Each 64-bit line shown as 16-bit portions
// - Each valid window read advances read pointer
// - Writing arm bit one locks the buffer
// - Byte or misaligned window read returns zero, no advance
// - Word read while armed returns zero, no advance
// - Store undefined after power-up, untouched by others
module trace_buffer_readout
   import trace_readout_pkg::*;
(
   // Clock, reset and enable
   input  wire logic              sys_clk,
   input  wire logic              reset_n,
   input  wire logic              clk_en,
   // Register port
   input  wire logic [ADDR_W-1:0] bus_addr,
   input  wire logic [DATA_W-1:0] bus_wdata,
   input  wire logic              bus_wstrb,
   input  wire logic              bus_rstrb,
   input  wire logic              bus_word,
   output      logic [DATA_W-1:0] bus_rdata,
   // Chip security state
   input  wire logic              chip_secured,
   // Trace capture stream
   input  wire logic              trace_in_valid,
   input  wire logic [LINE_W-1:0] trace_in_data,
   output      logic              trace_in_ready,
   // Capture state
   output      logic              capture_armed
);

   // Software visible state
   logic [SRC_W-1:0]   trace_origin_select;
   logic               unlocked;
   logic [PTR_W-1:0]   rd_ptr;
   logic [LINE_AW-1:0] wr_ptr;
   logic               wrapped;

   // Next values
   logic               next_capture_armed;
   logic [SRC_W-1:0]   next_trace_origin_select;
   logic               next_unlocked;
   logic [PTR_W-1:0]   next_rd_ptr;
   logic [LINE_AW-1:0] next_wr_ptr;
   logic               next_wrapped;
   logic [DATA_W-1:0]  next_rdata;

   // Decode and datapath wires
   logic               ctrl_hit;
   logic               status_hit;
   logic               wrptr_hit;
   logic               win_aligned;
   logic               ctrl_wr;
   logic               arm_bit;
   logic               arm_rise;
   logic               win_unlock;
   logic               read_allowed;
   logic               win_read_ok;
   logic               capture_go;
   logic               store_wr;
   logic [PTR_W-1:0]   oldest_ptr;
   logic [LINE_W-1:0]  line_data;
   logic [DATA_W-1:0]  portion;
   logic [DATA_W-1:0]  ctrl_value;
   logic [DATA_W-1:0]  status_value;
   logic [DATA_W-1:0]  wrptr_value;
   logic [DATA_W-1:0]  reg_value;
   logic               buf_valid;
   logic [LINE_W-1:0]  buf_data;

   // Capture stream passes through a two-entry buffer so a stall loses no line
   two_entry_buffer #(
      .WIDTH     (LINE_W)
   ) u_capture_buffer (
      .sys_clk   (sys_clk),
      .reset_n   (reset_n),
      .clk_en    (clk_en),
      .in_valid  (trace_in_valid),
      .in_ready  (trace_in_ready),
      .in_data   (trace_in_data),
      .out_valid (buf_valid),
      .out_ready (capture_go),
      .out_data  (buf_data)
   );

   // Line store, fed only from the capture side
   trace_line_store u_line_store (
      .sys_clk   (sys_clk),
      .clk_en    (clk_en),
      .wr_en     (store_wr),
      .wr_addr   (wr_ptr),
      .wr_data   (buf_data),
      .rd_addr   (rd_ptr[PTR_W-1:PART_AW]),
      .rd_data   (line_data)
   );

   // Address decode
   assign ctrl_hit    = (bus_addr == CTRL_ADDR);
   assign status_hit  = (bus_addr == STATUS_ADDR);
   assign wrptr_hit   = (bus_addr == WRPTR_ADDR);
   assign win_aligned = bus_word && (bus_addr == WIN_ADDR);

   // Control writes; arm bit rewrites re-lock even if already armed
   assign ctrl_wr  = bus_wstrb && ctrl_hit;
   assign arm_bit  = bus_wdata[CTRL_ARM_BIT];
   assign arm_rise = ctrl_wr && arm_bit && !capture_armed;

   // Unlock only by an aligned word write while disarmed
   assign win_unlock = bus_wstrb && win_aligned && !capture_armed;

   // Gate for a valid window read
   assign read_allowed = unlocked && !chip_secured && !capture_armed
                         && (trace_origin_select != SRC_RESET);
   assign win_read_ok  = bus_rstrb && win_aligned && read_allowed;

   // Capture drains the buffer only while armed with a source chosen;
   // otherwise the buffer fills and pushes back on the source
   assign capture_go = capture_armed && (trace_origin_select != SRC_RESET);
   assign store_wr   = buf_valid && capture_go;

   // After a wrap the oldest line sits at the write pointer
   assign oldest_ptr = wrapped ? {wr_ptr, PART_ZERO} : PTR_ZERO;

   // Portion select; low pointer bits pick 16 of the 64 bits
   assign portion = line_data[{rd_ptr[PART_AW-1:0], 4'h0} +: DATA_W];

   // Control and status images; unused bits read as zero
   assign ctrl_value   = {13'h0000, trace_origin_select, capture_armed};
   assign status_value = {rd_ptr, 4'h0, wrapped, chip_secured,
                          capture_armed, unlocked};
   assign wrptr_value  = {10'h000, wr_ptr};

   // Register read mux; window and unmapped addresses fall to zero
   assign reg_value = ctrl_hit   ? ctrl_value   :
                      status_hit ? status_value :
                      wrptr_hit  ? wrptr_value  : DATA_ZERO;

   // Read data stands only in the cycle after a read strobe
   assign next_rdata = !bus_rstrb  ? DATA_ZERO :
                       win_read_ok ? portion :
                       reg_value;

   // Arming state and source selection
   assign next_capture_armed       = ctrl_wr ? arm_bit : capture_armed;
   assign next_trace_origin_select = ctrl_wr ? bus_wdata[CTRL_SRC_LSB +: SRC_W]
                                             : trace_origin_select;

   // Lock on arm, unlock on window write; the two never share a cycle
   assign next_unlocked = (ctrl_wr && arm_bit) ? 1'b0 :
                          win_unlock ? 1'b1 : unlocked;

   // Read pointer: unlock rewinds to the oldest line, valid reads step it;
   // the portion bits carry into the line bits, so line order follows
   assign next_rd_ptr = win_unlock  ? oldest_ptr :
                        win_read_ok ? rd_ptr + PTR_ONE :
                        rd_ptr;

   // Write pointer restarts on each fresh arm and wraps round the store
   assign next_wr_ptr  = arm_rise ? LINE_ZERO :
                         store_wr ? wr_ptr + LINE_ONE : wr_ptr;
   assign next_wrapped = arm_rise ? 1'b0 :
                         (store_wr && wr_ptr == LAST_LINE) ? 1'b1 : wrapped;

   // Control state; the line store itself has no reset at all
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         capture_armed       <= 1'b0;
         trace_origin_select <= SRC_RESET;
         unlocked            <= 1'b0;
      end else if (clk_en) begin
         capture_armed       <= next_capture_armed;
         trace_origin_select <= next_trace_origin_select;
         unlocked            <= next_unlocked;
      end
   end

   // Pointers and wrap marker
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_ptr  <= PTR_ZERO;
         wr_ptr  <= LINE_ZERO;
         wrapped <= 1'b0;
      end else if (clk_en) begin
         rd_ptr  <= next_rd_ptr;
         wr_ptr  <= next_wr_ptr;
         wrapped <= next_wrapped;
      end
   end

   // Registered read data
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         bus_rdata <= DATA_ZERO;
      end else if (clk_en) begin
         bus_rdata <= next_rdata;
      end
   end

endmodule

/* sim/trace_readout_props.sv */
`timescale 1ns/1ps
module trace_readout_props
   import trace_readout_pkg::*;
(
   // Clock, reset and enable
   input wire logic              sys_clk,
   input wire logic              reset_n,
   input wire logic              clk_en,
   // Register port
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire logic [DATA_W-1:0] bus_wdata,
   input wire logic              bus_wstrb,
   input wire logic              bus_rstrb,
   input wire logic              bus_word,
   input wire logic [DATA_W-1:0] bus_rdata,
   // Security, stream and capture state
   input wire logic              chip_secured,
   input wire logic              trace_in_valid,
   input wire logic [LINE_W-1:0] trace_in_data,
   input wire logic              trace_in_ready,
   input wire logic              capture_armed
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   // Decoded window and control accesses
   wire rd_win   = clk_en && bus_rstrb && (bus_addr == WIN_ADDR);
   wire wr_ctrl  = clk_en && bus_wstrb && (bus_addr == CTRL_ADDR);

   a_rdata_idle: assert property (clk_en && !bus_rstrb |=> bus_rdata == DATA_ZERO)
      else $error("read data not zero outside a read");
   a_byte_read_zero: assert property (rd_win && !bus_word |=> bus_rdata == DATA_ZERO)
      else $error("byte window read not zero");
   a_misalign_zero: assert property (clk_en && bus_rstrb && bus_addr == WIN_ADDR_HI
      |=> bus_rdata == DATA_ZERO)
      else $error("misaligned window read not zero");
   a_armed_read_zero: assert property (rd_win && capture_armed |=> bus_rdata == DATA_ZERO)
      else $error("window read while armed not zero");
   a_secured_zero: assert property (rd_win && chip_secured |=> bus_rdata == DATA_ZERO)
      else $error("window read while secured not zero");
   a_arm_sets: assert property (wr_ctrl && bus_wdata[CTRL_ARM_BIT] |=> capture_armed)
      else $error("arm write did not arm");
   a_disarm_clears: assert property (wr_ctrl && !bus_wdata[CTRL_ARM_BIT] |=> !capture_armed)
      else $error("disarm write did not disarm");
   a_arm_holds: assert property (clk_en && !wr_ctrl |=> $stable(capture_armed))
      else $error("arm state moved without a control write");

   // Main scenarios
   c_window_read: cover property (rd_win && bus_word ##1 bus_rdata != DATA_ZERO);
   c_buffer_full: cover property (trace_in_valid && !trace_in_ready);
   c_arm_write: cover property (wr_ctrl && bus_wdata[CTRL_ARM_BIT]);
endmodule

bind trace_buffer_readout trace_readout_props props_u (
   .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .bus_addr(bus_addr),
   .bus_wdata(bus_wdata), .bus_wstrb(bus_wstrb), .bus_rstrb(bus_rstrb),
   .bus_word(bus_word), .bus_rdata(bus_rdata), .chip_secured(chip_secured),
   .trace_in_valid(trace_in_valid), .trace_in_data(trace_in_data),
   .trace_in_ready(trace_in_ready), .capture_armed(capture_armed));

/* sim/trace_buffer_readout_tb.sv */
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; \
   $display("ERROR %0t got %h expected %h", $time, (a), (b)); end end
module trace_buffer_readout_tb
   import trace_readout_pkg::*;
;
   logic              sys_clk = 1'b0;
   logic              reset_n = 1'b0;
   logic              clk_en = 1'b1;
   logic [ADDR_W-1:0] bus_addr = '0;
   logic [DATA_W-1:0] bus_wdata = '0;
   logic              bus_wstrb = 1'b0;
   logic              bus_rstrb = 1'b0;
   logic              bus_word = 1'b0;
   logic [DATA_W-1:0] bus_rdata;
   logic              chip_secured = 1'b0;
   logic              trace_in_valid = 1'b0;
   logic [LINE_W-1:0] trace_in_data = '0;
   logic              trace_in_ready;
   logic              capture_armed;
   int                n_fail = 0;
   int                check_count = 0;
   logic [LINE_W-1:0] lines [3] = '{64'h1a1b_2a2b_3a3b_4a4b, 64'h5c5d_6c6d_7c7d_8c8d,
                                    64'h9e9f_ae0f_be1f_ce2f};

   // 40 MHz system clock
   always #12.5 sys_clk = ~sys_clk;

   trace_buffer_readout dut_u (
      .sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wstrb(bus_wstrb), .bus_rstrb(bus_rstrb),
      .bus_word(bus_word), .bus_rdata(bus_rdata), .chip_secured(chip_secured),
      .trace_in_valid(trace_in_valid), .trace_in_data(trace_in_data),
      .trace_in_ready(trace_in_ready), .capture_armed(capture_armed));

   // Portion k of the captured stream, lowest 16 bits of each line first
   function automatic logic [DATA_W-1:0] part(input int k);
      return lines[k / 4][16 * (k % 4) +: 16];
   endfunction

   task automatic test_done();
      if (n_fail == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // One-cycle write, then a quiet cycle so strobes never collide
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      bus_addr <= a;
      bus_wdata <= d;
      bus_word <= 1'b1;
      bus_wstrb <= 1'b1;
      @(posedge sys_clk);
      bus_wstrb <= 1'b0;
      @(posedge sys_clk);
   endtask

   // One-cycle read; data is sampled mid-cycle in the following cycle only,
   // well away from the edge that launches or clears it
   task automatic rd(input logic [ADDR_W-1:0] a, input logic w, input logic [DATA_W-1:0] e);
      bus_addr <= a;
      bus_word <= w;
      bus_rstrb <= 1'b1;
      @(posedge sys_clk);
      bus_rstrb <= 1'b0;
      @(negedge sys_clk);
      `CHK(bus_rdata, e)
      @(posedge sys_clk);
   endtask

   // Holds the offered line until an edge sees ready high
   task automatic take();
      for (int i = 0; i < 40; i++) begin
         @(posedge sys_clk);
         if (trace_in_ready === 1'b1) return;
      end
      n_fail++;
      test_done();
   endtask

   initial begin
      repeat (8) @(posedge sys_clk);
      reset_n <= 1'b1;
      @(posedge sys_clk);
      rd(WIN_ADDR, 1'b1, DATA_ZERO);
      // Fill the buffer while disarmed until it refuses, then arm to drain it
      trace_in_valid <= 1'b1;
      trace_in_data <= lines[0];
      take();
      trace_in_data <= lines[1];
      take();
      trace_in_data <= lines[2];
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      `CHK(trace_in_ready, 1'b0)
      @(posedge sys_clk);
      wr(CTRL_ADDR, 16'h0003);
      take();
      trace_in_valid <= 1'b0;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      `CHK(capture_armed, 1'b1)
      @(posedge sys_clk);
      // Control reads back; three drained lines leave the write line at 3
      rd(CTRL_ADDR, 1'b1, 16'h0003);
      rd(WRPTR_ADDR, 1'b1, 16'h0003);
      rd(WIN_ADDR, 1'b1, DATA_ZERO);
      wr(WIN_ADDR, 16'hffff);
      wr(CTRL_ADDR, 16'h0002);
      rd(WIN_ADDR, 1'b1, DATA_ZERO);
      wr(WIN_ADDR, 16'h5a5a);
      // Walk portions across a line boundary, with refused reads in between
      for (int k = 0; k < 6; k++) begin
         rd(WIN_ADDR, 1'b1, part(k));
         if (k == 1) begin
            rd(WIN_ADDR, 1'b0, DATA_ZERO);
            rd(WIN_ADDR_HI, 1'b1, DATA_ZERO);
         end
      end
      chip_secured <= 1'b1;
      rd(WIN_ADDR, 1'b1, DATA_ZERO);
      chip_secured <= 1'b0;
      rd(WIN_ADDR, 1'b1, part(6));
      wr(CTRL_ADDR, 16'h0000);
      rd(WIN_ADDR, 1'b1, DATA_ZERO);
      wr(CTRL_ADDR, 16'h0002);
      rd(WIN_ADDR, 1'b1, part(7));
      // Unlock write rewinds but leaves the stored lines as they were
      wr(WIN_ADDR, 16'h0000);
      rd(WIN_ADDR, 1'b1, part(0));
      rd(STATUS_ADDR, 1'b1, 16'h0101);
      // Frozen clock enable ignores a window read: no data, no step
      clk_en <= 1'b0;
      rd(WIN_ADDR, 1'b1, DATA_ZERO);
      clk_en <= 1'b1;
      rd(WIN_ADDR, 1'b1, part(1));
      wr(CTRL_ADDR, 16'h0003);
      wr(CTRL_ADDR, 16'h0002);
      rd(WIN_ADDR, 1'b1, DATA_ZERO);
      rd(8'h30, 1'b1, DATA_ZERO);
      test_done();
   end
endmodule
